// *** inc/aco_cfg.svh ***
// register offsets, field positions, command codes and reset values
// for the axis coordinate block; included by the package, aco_axis and the testbench
`ifndef ACO_CFG_SVH
`define ACO_CFG_SVH

`define ACO_AW 8
`define ACO_OFS_CTRL 8'h00
`define ACO_OFS_ROT_END 8'h04
`define ACO_OFS_LIM_START 8'h08
`define ACO_OFS_LIM_END 8'h0C
`define ACO_OFS_VALUE 8'h10
`define ACO_OFS_CMD 8'h14
`define ACO_OFS_ACT_DISP 8'h18
`define ACO_OFS_STATUS 8'h1C
`define ACO_OFS_ACT_POS 8'h20
`define ACO_OFS_ZERO_OFS 8'h24
`define ACO_OFS_ENC_ADJ 8'h28
`define ACO_OFS_SLS_SHIFT 8'h2C
`define ACO_OFS_SLE_SHIFT 8'h30

`define ACO_CTRL_ROTARY 0
`define ACO_CTRL_ABS 1
`define ACO_ST_SYNCED 0
`define ACO_ST_CONFIGURED 1
`define ACO_ST_ZO_ACTIVE 2
`define ACO_ST_ERROR 3

`define ACO_CMD_UNDO 2'h1
`define ACO_CMD_ZERO 2'h2
`define ACO_CMD_REF 2'h3

`define ACO_RST_ROT_END 32'h00000168

`endif

// *** inc/aco_pkg.sv ***
// types shared by the axis coordinate block
// assumes aco_cfg.svh is on the include path
package aco_pkg;
  `include "aco_cfg.svh"
  typedef enum logic [1:0] {
    ACO_OP_NONE,
    ACO_OP_UNDO,
    ACO_OP_ZERO,
    ACO_OP_REF
  } aco_op_t;
endpackage

// *** hdl/aco_wrap.sv ***
// registered coordinate normaliser for one value
// assumes the value lies within one axis length of the range 0..end
`timescale 1ns/1ps
module aco_wrap #(
  parameter int W = 32
) (
  // clock
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // value in
  input wire logic signed [W-1:0] value,
  input wire logic signed [W-1:0] rot_end,
  input wire logic rotary,
  // value out
  output logic signed [W-1:0] wrapped
);
  wire logic below_zero;
  wire logic at_or_over;
  wire logic signed [W-1:0] next_wrapped;

  assign below_zero = value < 0;
  // reaching the end value already counts as a full turn
  assign at_or_over = value >= rot_end;
  assign next_wrapped = !rotary ? value :
                        below_zero ? W'(value + rot_end) :
                        at_or_over ? W'(value - rot_end) : value;

  always_ff @(posedge clk) begin
    if (srst) begin
      wrapped <= '0;
    end else if (ce) begin
      wrapped <= next_wrapped;
    end
  end
endmodule

// *** hdl/aco_axis.sv ***
// coordinate handling for one positioning axis: zero offset,
// reference point, undo of actual value displacement
// assumes enc_pos comes from logic on clk; software uses the plain port
//
// Functional notes
// RULE1: undo clears set-actual-value displacement
// RULE2: zero offset shifts the coordinate origin
// RULE3: offset sign sets shift direction
// RULE4: new value is old minus offset change
// RULE5: zero offset only while axis synchronized
// RULE6: linear offset keeps limits in range
// RULE7: rotary offset below rotary end value
// RULE8: sync loss keeps zero offset active
// RULE9: new offset replaces old, from origin
// RULE10: offset zero cancels the zero offset
// RULE11: rotary result above end subtracts end
// RULE12: rotary position wraps to zero at end
// RULE13: offset renumbers points, range stays put
// RULE14: reference point setting synchronizes axis
// RULE15: reference point only after configuration
// RULE16: linear reference between the soft limits
// RULE17: rotary reference from zero below end
// RULE18: reference point loads the actual position
// RULE19: reference moves range, limits keep values
// RULE20: absolute encoder stores adjustment at reference
// RULE21: bad requests rejected, error flagged
`timescale 1ns/1ps
`include "aco_cfg.svh"
module aco_axis #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic [`ACO_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // axis side
  input wire logic signed [W-1:0] enc_pos,
  input wire logic sync_lost,
  output logic signed [W-1:0] actual_position,
  output logic synced,
  output logic cmd_error
);
  import aco_pkg::*;

  // difference that does not leave the signed range
  function automatic logic sub_fits(input logic signed [W-1:0] a,
                                    input logic signed [W-1:0] b);
    logic signed [W:0] d;
    d = {a[W-1], a} - {b[W-1], b};
    return d[W] == d[W-1];
  endfunction

  // configuration and operands
  logic rotary;
  logic abs_enc;
  logic configured;
  logic signed [W-1:0] rot_end;
  logic signed [W-1:0] soft_limit_start;
  logic signed [W-1:0] soft_limit_end;
  logic signed [W-1:0] cmd_value;
  // coordinate state
  logic signed [W-1:0] act_disp;
  logic signed [W-1:0] ref_adjust;
  logic signed [W-1:0] zero_offset_value;
  logic zo_active;
  logic signed [W-1:0] enc_adjust;
  logic signed [W-1:0] sls_shift;
  logic signed [W-1:0] sle_shift;

  // bus decode
  wire logic wr_ctrl;
  wire logic wr_rot_end;
  wire logic wr_lim_start;
  wire logic wr_lim_end;
  wire logic wr_value;
  wire logic wr_cmd;
  wire logic wr_disp;
  wire logic wr_status;
  wire logic err_clr;

  assign wr_ctrl = reg_wr && reg_addr == `ACO_OFS_CTRL;
  assign wr_rot_end = reg_wr && reg_addr == `ACO_OFS_ROT_END;
  assign wr_lim_start = reg_wr && reg_addr == `ACO_OFS_LIM_START;
  assign wr_lim_end = reg_wr && reg_addr == `ACO_OFS_LIM_END;
  assign wr_value = reg_wr && reg_addr == `ACO_OFS_VALUE;
  assign wr_cmd = reg_wr && reg_addr == `ACO_OFS_CMD;
  assign wr_disp = reg_wr && reg_addr == `ACO_OFS_ACT_DISP;
  assign wr_status = reg_wr && reg_addr == `ACO_OFS_STATUS;
  assign err_clr = wr_status && reg_wdata[`ACO_ST_ERROR];

  // command decode
  wire aco_op_t op;
  assign op = !wr_cmd ? ACO_OP_NONE :
              reg_wdata[1:0] == `ACO_CMD_UNDO ? ACO_OP_UNDO :
              reg_wdata[1:0] == `ACO_CMD_ZERO ? ACO_OP_ZERO :
              reg_wdata[1:0] == `ACO_CMD_REF ? ACO_OP_REF : ACO_OP_NONE;

  // precondition checks
  wire logic zo_rot_ok;
  wire logic zo_lin_ok;
  wire logic zo_ok;
  wire logic ref_rot_ok;
  wire logic ref_lin_ok;
  wire logic ref_ok;
  wire logic zo_take;
  wire logic ref_take;
  wire logic undo_take;
  wire logic cmd_bad;

  // offset magnitude must stay below one turn
  assign zo_rot_ok = cmd_value < rot_end && cmd_value > -rot_end; // [RULE7]
  assign zo_lin_ok = sub_fits(soft_limit_start, cmd_value) &&
                     sub_fits(soft_limit_end, cmd_value); // [RULE6]
  assign zo_ok = synced && (rotary ? zo_rot_ok : zo_lin_ok); // [RULE5]
  assign ref_rot_ok = cmd_value >= 0 && cmd_value < rot_end; // [RULE17]
  assign ref_lin_ok = cmd_value >= soft_limit_start &&
                      cmd_value <= soft_limit_end; // [RULE16]
  assign ref_ok = configured &&
                  (rotary ? ref_rot_ok : ref_lin_ok); // [RULE15]
  assign zo_take = op == ACO_OP_ZERO && zo_ok;
  assign ref_take = op == ACO_OP_REF && ref_ok;
  assign undo_take = op == ACO_OP_UNDO;
  // rejected requests leave every coordinate alone
  assign cmd_bad = (op == ACO_OP_ZERO && !zo_ok) ||
                   (op == ACO_OP_REF && !ref_ok); // [RULE21]

  // coordinate arithmetic
  wire logic signed [W-1:0] raw_pos;
  wire logic signed [W-1:0] act_lin;
  wire logic signed [W-1:0] sls_lin;
  wire logic signed [W-1:0] sle_lin;
  wire logic signed [W-1:0] next_ref_adjust;
  wire logic signed [W-1:0] next_enc_adjust;

  assign raw_pos = W'(enc_pos + ref_adjust + act_disp);
  // the whole offset is subtracted from the unshifted coordinate, so a
  // change yields old value minus (new offset - old offset)
  assign act_lin = W'(raw_pos - zero_offset_value); // [RULE4] [RULE3]
  // limits keep their physical spot, only their numbers move
  assign sls_lin = W'(soft_limit_start - zero_offset_value); // [RULE13]
  assign sle_lin = W'(soft_limit_end - zero_offset_value); // [RULE13]
  // adjustment chosen so that the shown position equals the operand
  assign next_ref_adjust = W'(cmd_value - enc_pos - act_disp +
                              zero_offset_value); // [RULE18] [RULE19]
  assign next_enc_adjust = W'(cmd_value - enc_pos); // [RULE20]

  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rotary <= 1'b0;
      abs_enc <= 1'b0;
      configured <= 1'b0;
    end else if (ce && wr_ctrl) begin
      rotary <= reg_wdata[`ACO_CTRL_ROTARY];
      abs_enc <= reg_wdata[`ACO_CTRL_ABS];
      configured <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rot_end <= W'(`ACO_RST_ROT_END);
      soft_limit_start <= '0;
      soft_limit_end <= '0;
      cmd_value <= '0;
    end else if (ce) begin
      if (wr_rot_end) begin
        rot_end <= W'(reg_wdata);
      end
      if (wr_lim_start) begin
        soft_limit_start <= W'(reg_wdata);
      end
      if (wr_lim_end) begin
        soft_limit_end <= W'(reg_wdata);
      end
      if (wr_value) begin
        cmd_value <= W'(reg_wdata);
      end
    end
  end

  // displacement left by set actual value
  always_ff @(posedge clk) begin
    if (srst) begin
      act_disp <= '0;
    end else if (ce) begin
      if (undo_take) begin
        act_disp <= '0; // [RULE1]
      end else if (wr_disp) begin
        act_disp <= W'(reg_wdata);
      end
    end
  end

  // zero offset register; a new one simply replaces the old
  always_ff @(posedge clk) begin
    if (srst) begin
      zero_offset_value <= '0;
      zo_active <= 1'b0;
    end else if (ce && zo_take) begin
      zero_offset_value <= cmd_value; // [RULE2] [RULE9]
      zo_active <= cmd_value != 0; // [RULE10]
    end
  end

  // reference point and synchronisation
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_adjust <= '0;
      enc_adjust <= '0;
      synced <= 1'b0;
    end else if (ce) begin
      if (ref_take) begin
        ref_adjust <= next_ref_adjust; // [RULE18]
        synced <= 1'b1; // [RULE14]
        if (abs_enc) begin
          enc_adjust <= next_enc_adjust; // [RULE20]
        end
      end else if (sync_lost) begin
        // offset registers untouched here
        synced <= 1'b0; // [RULE8]
      end
    end
  end

  // sticky error; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_error <= 1'b0;
    end else if (ce) begin
      if (cmd_bad) begin
        cmd_error <= 1'b1; // [RULE21]
      end else if (err_clr) begin
        cmd_error <= 1'b0;
      end
    end
  end

  // rotary wrap of shown position and shifted limits
  aco_wrap #(.W(W)) u_wrap_act (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .value(act_lin),
    .rot_end(rot_end),
    .rotary(rotary),
    .wrapped(actual_position) // [RULE11] [RULE12]
  );

  aco_wrap #(.W(W)) u_wrap_sls (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .value(sls_lin),
    .rot_end(rot_end),
    .rotary(rotary),
    .wrapped(sls_shift)
  );

  aco_wrap #(.W(W)) u_wrap_sle (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .value(sle_lin),
    .rot_end(rot_end),
    .rotary(rotary),
    .wrapped(sle_shift)
  );

  // read mux
  wire logic [31:0] status_word;
  wire logic [31:0] next_rdata;

  assign status_word = {28'h0000000, cmd_error, zo_active,
                        configured, synced};
  assign next_rdata =
    reg_addr == `ACO_OFS_CTRL ? {30'h00000000, abs_enc, rotary} :
    reg_addr == `ACO_OFS_ROT_END ? 32'(rot_end) :
    reg_addr == `ACO_OFS_LIM_START ? 32'(soft_limit_start) :
    reg_addr == `ACO_OFS_LIM_END ? 32'(soft_limit_end) :
    reg_addr == `ACO_OFS_VALUE ? 32'(cmd_value) :
    reg_addr == `ACO_OFS_ACT_DISP ? 32'(act_disp) :
    reg_addr == `ACO_OFS_STATUS ? status_word :
    reg_addr == `ACO_OFS_ACT_POS ? 32'(actual_position) :
    reg_addr == `ACO_OFS_ZERO_OFS ? 32'(zero_offset_value) :
    reg_addr == `ACO_OFS_ENC_ADJ ? 32'(enc_adjust) :
    reg_addr == `ACO_OFS_SLS_SHIFT ? 32'(sls_shift) :
    reg_addr == `ACO_OFS_SLE_SHIFT ? 32'(sle_shift) : 32'h00000000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  // checks
  a_undo_clears: assert property (@(posedge clk) disable iff (srst) // [RULE1]
    ce && undo_take |=> act_disp == 0)
    else $error("undo did not clear displacement");

  a_zo_loads: assert property (@(posedge clk) disable iff (srst) // [RULE2]
    ce && zo_take |=> zero_offset_value == $past(cmd_value)
      && zo_active == ($past(cmd_value) != 0))
    else $error("zero offset not taken");

  a_zo_shift: assert property (@(posedge clk) disable iff (srst) // [RULE13]
    ce && zo_take && !rotary ##1 ce |=>
      sls_shift == $past(soft_limit_start) - $past(zero_offset_value))
    else $error("shifted start limit wrong");

  a_sync_keep_zo: assert property (@(posedge clk) disable iff (srst) // [RULE8]
    ce && sync_lost && !ref_take && !zo_take |=>
      !synced && $stable(zero_offset_value) && $stable(zo_active))
    else $error("sync loss disturbed zero offset");

  a_ref_sync: assert property (@(posedge clk) disable iff (srst) // [RULE14]
    ce && ref_take |=> synced && $stable(soft_limit_start))
    else $error("reference point did not synchronise");

  a_ref_position: assert property (@(posedge clk) disable iff (srst) // [RULE18]
    ce && ref_take ##1 ce && $stable(enc_pos) && !wr_disp |=>
      actual_position == $past(cmd_value, 2))
    else $error("actual position not loaded with reference");

  a_abs_adjust: assert property (@(posedge clk) disable iff (srst) // [RULE20]
    ce && ref_take && abs_enc |=>
      enc_adjust == $past(cmd_value) - $past(enc_pos))
    else $error("encoder adjustment wrong");

  a_rot_range: assert property (@(posedge clk) disable iff (srst) // [RULE12]
    ce && rotary && $stable(rotary) && act_lin >= 0
      && act_lin < 2 * rot_end |=>
      actual_position >= 0 && actual_position < $past(rot_end))
    else $error("rotary position outside one turn");

  a_bad_reject: assert property (@(posedge clk) disable iff (srst) // [RULE21]
    ce && cmd_bad |=> cmd_error && $stable(zero_offset_value)
      && $stable(ref_adjust))
    else $error("bad request not rejected");

  a_unsync_zo: assert property (@(posedge clk) disable iff (srst) // [RULE5]
    ce && op == ACO_OP_ZERO && !synced |=> cmd_error)
    else $error("zero offset accepted while unsynchronised");
endmodule

// *** tb/tb_aco_axis.sv ***
// self-checking bench for the axis coordinate block
// assumes aco_pkg and aco_cfg.svh are compiled and on the include path
`timescale 1ns/1ps
`include "aco_cfg.svh"
module tb_aco_axis;
  import aco_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [`ACO_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [31:0] enc_pos = 32'h000003E8;
  logic sync_lost = 1'b0;
  logic signed [31:0] actual_position;
  logic synced;
  logic cmd_error;
  int bad_count = 0;
  int compares = 0;

  always #20 clk = ~clk;

  aco_axis #(.W(32)) i_aco_axis (
    .clk(clk), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enc_pos(enc_pos), .sync_lost(sync_lost),
    .actual_position(actual_position), .synced(synced),
    .cmd_error(cmd_error)
  );

  task automatic complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask

  // settle: three edges, margin over the single registered wrap stage (arithmetic is combinational)
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [31:0] v, input logic [1:0] c);
    wr(`ACO_OFS_VALUE, v);
    wr(`ACO_OFS_CMD, {30'h0, c});
    settle();
  endtask

  task automatic pos_is(input logic [31:0] e);
    chk("actual_position", e, actual_position);
  endtask

  task automatic clear_error;
    wr(`ACO_OFS_STATUS, 32'h00000008);
    settle();
    chk("cmd_error", 32'h0, {31'h0, cmd_error});
  endtask

  // reset values, unmapped read, reference before configuration
  task automatic t_reset;
    rd(`ACO_OFS_ROT_END, `ACO_RST_ROT_END, "rot_end");
    rd(`ACO_OFS_STATUS, 32'h0, "status");
    rd(8'hFC, 32'h0, "unmapped");
    cmd(32'h0, `ACO_CMD_REF);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    chk("synced", 32'h0, {31'h0, synced});
    clear_error();
  endtask

  // linear axis, absolute encoder reference point
  task automatic t_ref_abs;
    wr(`ACO_OFS_CTRL, 32'h00000002);
    wr(`ACO_OFS_LIM_START, -32'h000001F4);
    wr(`ACO_OFS_LIM_END, 32'h000001F4);
    cmd(32'h00000258, `ACO_CMD_REF);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    clear_error();
    cmd(-32'h000000C8, `ACO_CMD_REF);
    chk("synced", 32'h1, {31'h0, synced});
    pos_is(-32'h000000C8);
    rd(`ACO_OFS_ENC_ADJ, -32'h000004B0, "enc_adj");
  endtask

  // apply, change and revoke a zero offset
  task automatic t_zero;
    cmd(32'h80000000, `ACO_CMD_ZERO);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    rd(`ACO_OFS_ZERO_OFS, 32'h0, "zero_ofs");
    clear_error();
    cmd(-32'h000000C8, `ACO_CMD_ZERO);
    pos_is(32'h0);
    rd(`ACO_OFS_ZERO_OFS, -32'h000000C8, "zero_ofs");
    rd(`ACO_OFS_SLS_SHIFT, -32'h0000012C, "sls_shift");
    rd(`ACO_OFS_SLE_SHIFT, 32'h000002BC, "sle_shift");
    rd(`ACO_OFS_STATUS, 32'h00000007, "status");
    cmd(32'h00000064, `ACO_CMD_ZERO);
    pos_is(-32'h0000012C);
    cmd(32'h0, `ACO_CMD_ZERO);
    pos_is(-32'h000000C8);
    rd(`ACO_OFS_STATUS, 32'h00000003, "status");
  endtask

  // displacement left by set actual value, then undone
  task automatic t_undo;
    wr(`ACO_OFS_ACT_DISP, 32'h00000032);
    settle();
    pos_is(-32'h00000096);
    cmd(32'h0, `ACO_CMD_UNDO);
    pos_is(-32'h000000C8);
    rd(`ACO_OFS_ACT_DISP, 32'h0, "act_disp");
  endtask

  // sync loss keeps the offset; offset refused while unsynced
  task automatic t_sync_loss;
    cmd(-32'h000000C8, `ACO_CMD_ZERO);
    @(posedge clk);
    sync_lost <= 1'b1;
    @(posedge clk);
    sync_lost <= 1'b0;
    settle();
    chk("synced", 32'h0, {31'h0, synced});
    rd(`ACO_OFS_ZERO_OFS, -32'h000000C8, "zero_ofs");
    rd(`ACO_OFS_STATUS, 32'h00000006, "status");
    cmd(32'h00000064, `ACO_CMD_ZERO);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    rd(`ACO_OFS_ZERO_OFS, -32'h000000C8, "zero_ofs");
    pos_is(32'h0);
    clear_error();
  endtask

  // rotary axis: wrap at the end and offset past the end
  task automatic t_rotary;
    wr(`ACO_OFS_CTRL, 32'h00000001);
    wr(`ACO_OFS_ROT_END, 32'h00000168);
    cmd(32'h00000168, `ACO_CMD_REF);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    clear_error();
    cmd(32'h00000154, `ACO_CMD_REF);
    pos_is(32'h00000154);
    @(posedge clk);
    enc_pos <= enc_pos + 32'h0000001E;
    settle();
    pos_is(32'h0000000A);
    @(posedge clk);
    enc_pos <= enc_pos - 32'h0000001E;
    settle();
    pos_is(32'h00000154);
    cmd(-32'h000000F5, `ACO_CMD_ZERO);
    pos_is(32'h00000019);
    cmd(32'h00000168, `ACO_CMD_ZERO);
    chk("cmd_error", 32'h1, {31'h0, cmd_error});
    rd(`ACO_OFS_ZERO_OFS, -32'h000000F5, "zero_ofs");
    clear_error();
  endtask

  // a write while the clock enable is low must be lost
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(`ACO_OFS_LIM_START, 32'h00000000);
    @(posedge clk);
    ce <= 1'b1;
    rd(`ACO_OFS_LIM_START, -32'h000001F4, "frozen_write");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ref_abs();
    t_zero();
    t_undo();
    t_sync_loss();
    t_rotary();
    t_freeze();
    complete_run();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
